// ===== hw/pmc_pkg.sv
// Purpose: shared constants for the power mode control block
// Assumes: 100 MHz mclk, 16-bit register address, 4-bit register data
// Notes:   wait times are kept in ms and turned into cycle counts here
package pmc_pkg;

  // register port widths
  localparam int unsigned PMC_ADDR_W = 16;
  localparam int unsigned PMC_DATA_W = 4;

  // register offsets
  localparam logic [15:0] PMC_OFF_SUPPLY   = 16'hFF00;
  localparam logic [15:0] PMC_OFF_LCDPWR   = 16'hFF60;
  localparam logic [15:0] PMC_OFF_OSC      = 16'hFF01;
  localparam logic [15:0] PMC_OFF_CONTRAST = 16'hFF02;
  localparam logic [15:0] PMC_OFF_STATUS   = 16'hFF03;

  // supply control field positions
  localparam int unsigned PMC_BIT_LVS = 0;  // logic_voltage_select
  localparam int unsigned PMC_BIT_FRO = 1;  // fast_regulator_on
  localparam int unsigned PMC_BIT_SRH = 2;  // slow_regulator_halver
  localparam int unsigned PMC_BIT_LSH = 3;  // lcd_supply_halver
  // lcd power register field
  localparam int unsigned PMC_BIT_LSO = 0;  // lcd_supply_on
  // oscillator control field positions
  localparam int unsigned PMC_BIT_CCS = 0;  // cpu_clock_select
  localparam int unsigned PMC_BIT_FOE = 1;  // fast_osc_enable
  // status field positions
  localparam int unsigned PMC_BIT_ST_VD3  = 0;
  localparam int unsigned PMC_BIT_ST_OSC  = 1;
  localparam int unsigned PMC_BIT_ST_LCD  = 2;
  localparam int unsigned PMC_BIT_ST_HALV = 3;

  // values after reset
  localparam logic [3:0] PMC_RST_SUPPLY   = 4'h0;
  localparam logic       PMC_RST_LCDPWR   = 1'b0;
  localparam logic [1:0] PMC_RST_OSC      = 2'h0;
  localparam logic [3:0] PMC_RST_CONTRAST = 4'h0;
  localparam logic [3:0] PMC_RD_NONE      = 4'h0;

  // wait times and their cycle counts, least times rounded up
  localparam real PMC_CLK_NS      = 10.0;
  localparam real PMC_VD3_WAIT_MS = 2.5;
  localparam real PMC_OSC_WAIT_MS = 5.0;
  localparam real PMC_LCD_WAIT_MS = 100.0;
  localparam int unsigned PMC_VD3_WAIT_CYC =
    int'($ceil(PMC_VD3_WAIT_MS * 1.0e6 / PMC_CLK_NS));
  localparam int unsigned PMC_OSC_WAIT_CYC =
    int'($ceil(PMC_OSC_WAIT_MS * 1.0e6 / PMC_CLK_NS));
  localparam int unsigned PMC_LCD_WAIT_CYC =
    int'($ceil(PMC_LCD_WAIT_MS * 1.0e6 / PMC_CLK_NS));
  localparam int unsigned PMC_TMR_W   = 24;
  localparam int unsigned PMC_NUM_TMR = 3;

  // address match, used by both write and read decode
  function automatic logic pmc_hit(input logic [15:0] addr,
                                   input logic [15:0] off);
    return addr == off;
  endfunction

endpackage

// ===== hw/pmc_power_ctrl.sv
// Purpose: power mode control bits, supply outputs and settle status
// Assumes: CPU register port, one access at a time, read data next cycle
// Notes:   sequencing is up to software; status shows elapsed waits
//
// Function
// - slow regulator always runs on slow clock
// - fast regulator on only while bit set
// - lcd supply follows lcd_supply_on bit
// - lcd base voltage has 16 settings
// - external lcd option keeps lcd supply off
// - two bits select halver per circuit
// - reset leaves both circuits in normal mode
// - voltage halver runs at all times
// - reset clears supply, clock and oscillator bits
// - halver bits act independently of each other
// - supply bits 0 to 3 in one register
// - lcd off grounds all lcd drive voltages
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int unsigned VD3_WAIT_CYCLES = PMC_VD3_WAIT_CYC,
  parameter int unsigned OSC_WAIT_CYCLES = PMC_OSC_WAIT_CYC,
  parameter int unsigned LCD_WAIT_CYCLES = PMC_LCD_WAIT_CYC,
  parameter bit          EXT_LCD_SUPPLY  = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic [PMC_ADDR_W-1:0] reg_addr,
  input  wire logic [PMC_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [PMC_DATA_W-1:0] reg_rdata,
  output logic                       logic_voltage_select,
  output logic                       fast_regulator_on,
  output logic                       slow_regulator_halver,
  output logic                       lcd_supply_halver,
  output logic                       lcd_supply_on,
  output logic                       lcd_drive_grounded,
  output logic                       cpu_clock_select,
  output logic                       fast_osc_enable,
  output logic      [3:0]            lcd_contrast_level,
  output logic                       slow_regulator_on,
  output logic                       voltage_halver_on
);

  // control registers
  logic [3:0]            supply_reg;
  logic [3:0]            supply_next;
  logic                  lcdpwr_reg;
  logic                  lcdpwr_next;
  logic [1:0]            osc_reg;
  logic [1:0]            osc_next;
  logic [3:0]            contrast_reg;
  logic [3:0]            contrast_next;
  logic [PMC_DATA_W-1:0] rdata_reg;
  logic [PMC_DATA_W-1:0] rdata_next;

  // write and read decode
  wire wr_supply   = reg_wr && pmc_hit(reg_addr, PMC_OFF_SUPPLY);
  wire wr_lcdpwr   = reg_wr && pmc_hit(reg_addr, PMC_OFF_LCDPWR);
  wire wr_osc      = reg_wr && pmc_hit(reg_addr, PMC_OFF_OSC);
  wire wr_contrast = reg_wr && pmc_hit(reg_addr, PMC_OFF_CONTRAST);
  wire rd_supply   = pmc_hit(reg_addr, PMC_OFF_SUPPLY);
  wire rd_lcdpwr   = pmc_hit(reg_addr, PMC_OFF_LCDPWR);
  wire rd_osc      = pmc_hit(reg_addr, PMC_OFF_OSC);
  wire rd_contrast = pmc_hit(reg_addr, PMC_OFF_CONTRAST);
  wire rd_status   = pmc_hit(reg_addr, PMC_OFF_STATUS);

  // next values: a write lands on the edge that takes it
  assign supply_next   = wr_supply ? reg_wdata : supply_reg;
  assign lcdpwr_next   = wr_lcdpwr ? reg_wdata[PMC_BIT_LSO] : lcdpwr_reg;
  assign osc_next      = wr_osc ? reg_wdata[1:0] : osc_reg;
  assign contrast_next = wr_contrast ? reg_wdata : contrast_reg;

  // control register update; reset returns all to normal and off
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      supply_reg   <= PMC_RST_SUPPLY;
      lcdpwr_reg   <= PMC_RST_LCDPWR;
      osc_reg      <= PMC_RST_OSC;
      contrast_reg <= PMC_RST_CONTRAST;
    end else begin
      supply_reg   <= supply_next;
      lcdpwr_reg   <= lcdpwr_next;
      osc_reg      <= osc_next;
      contrast_reg <= contrast_next;
    end
  end

  // supply control outputs, one field each
  assign logic_voltage_select  = supply_reg[PMC_BIT_LVS];
  assign fast_regulator_on     = supply_reg[PMC_BIT_FRO];
  assign slow_regulator_halver = supply_reg[PMC_BIT_SRH];
  // lcd circuit is held inactive when driven from outside
  assign lcd_supply_halver = supply_reg[PMC_BIT_LSH]
                             && !EXT_LCD_SUPPLY;
  assign lcd_supply_on     = lcdpwr_reg && !EXT_LCD_SUPPLY;
  assign lcd_drive_grounded = !lcd_supply_on;
  assign lcd_contrast_level = contrast_reg;

  // oscillator side bits
  assign cpu_clock_select = osc_reg[PMC_BIT_CCS];
  assign fast_osc_enable  = osc_reg[PMC_BIT_FOE];

  // always-running circuits
  assign slow_regulator_on = 1'b1;
  assign voltage_halver_on = 1'b1;

  // settle timers: fast supply, fast oscillator, lcd supply
  pmc_timer_if tmr_bus [PMC_NUM_TMR] ();

  // arm each wait while its enabling bits hold
  assign tmr_bus[0].arm = logic_voltage_select && fast_regulator_on;
  assign tmr_bus[1].arm = fast_osc_enable;
  assign tmr_bus[2].arm = lcd_supply_on;

  genvar gi;
  generate
    for (gi = 0; gi < PMC_NUM_TMR; gi++) begin : g_tmr
      localparam int unsigned CNT = (gi == 0) ? VD3_WAIT_CYCLES :
                                    (gi == 1) ? OSC_WAIT_CYCLES :
                                                LCD_WAIT_CYCLES;
      pmc_settle_timer #(
        .COUNT (CNT)
      ) u_tmr (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .tif     (tmr_bus[gi])
      );
    end
  endgenerate

  // status: elapsed waits and whether slow halver is currently safe
  wire vd3_settled = tmr_bus[0].done;
  wire osc_settled = tmr_bus[1].done;
  wire lcd_settled = tmr_bus[2].done;
  wire halver_ok   = !logic_voltage_select && !cpu_clock_select
                     && !fast_osc_enable && !fast_regulator_on;
  wire [3:0] status_word = {halver_ok, lcd_settled, osc_settled,
                            vd3_settled};

  // read selection; unmapped addresses and lcd upper bits read zero
  wire [3:0] rd_value =
    rd_supply   ? supply_reg :
    rd_lcdpwr   ? {3'h0, lcdpwr_reg} :
    rd_osc      ? {2'h0, osc_reg} :
    rd_contrast ? contrast_reg :
    rd_status   ? status_word : PMC_RD_NONE;
  assign rdata_next = reg_rd ? rd_value : PMC_RD_NONE;

  // read data register, valid the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_reg <= PMC_RD_NONE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_supply;
    reg_wr && pmc_hit(reg_addr, PMC_OFF_SUPPLY);
  endsequence

  sequence s_rd_supply;
    reg_rd && pmc_hit(reg_addr, PMC_OFF_SUPPLY);
  endsequence

  sequence s_wr_lcd_on;
    reg_wr && pmc_hit(reg_addr, PMC_OFF_LCDPWR) && reg_wdata[0];
  endsequence

  sequence s_wr_lcd_off;
    reg_wr && pmc_hit(reg_addr, PMC_OFF_LCDPWR) && !reg_wdata[PMC_BIT_LSO];
  endsequence

  sequence s_wr_osc;
    reg_wr && pmc_hit(reg_addr, PMC_OFF_OSC);
  endsequence

  sequence s_rd_osc;
    reg_rd && pmc_hit(reg_addr, PMC_OFF_OSC);
  endsequence

  sequence s_rd_status;
    reg_rd && pmc_hit(reg_addr, PMC_OFF_STATUS);
  endsequence

  chk_slow_reg_runs: assert property (
    !cpu_clock_select |-> slow_regulator_on)
    else $error("slow regulator off while on slow clock");

  chk_fast_reg_write: assert property (
    s_wr_supply |=> fast_regulator_on == $past(reg_wdata[1]))
    else $error("fast regulator does not follow its bit");

  chk_fast_reg_hold: assert property (
    !(reg_wr && pmc_hit(reg_addr, PMC_OFF_SUPPLY))
    |=> $stable(fast_regulator_on))
    else $error("fast regulator changed without a write");

  chk_lcd_power_on: assert property (
    s_wr_lcd_on ##1 !EXT_LCD_SUPPLY |-> lcd_supply_on)
    else $error("lcd supply not on after write of one");

  chk_lcd_grounded: assert property (
    $fell(lcdpwr_reg) |-> lcd_drive_grounded && !lcd_supply_on)
    else $error("lcd drive not grounded after power off");

  chk_contrast_span: assert property (
    reg_wr && pmc_hit(reg_addr, PMC_OFF_CONTRAST)
    |=> lcd_contrast_level == $past(reg_wdata))
    else $error("lcd contrast setting not taken");

  chk_ext_lcd_off: assert property (
    EXT_LCD_SUPPLY |-> !lcd_supply_on && !lcd_supply_halver)
    else $error("lcd supply active with external option");

  chk_halver_indep: assert property (
    s_wr_supply |=> slow_regulator_halver == $past(reg_wdata[2])
      && lcd_supply_halver == ($past(reg_wdata[3]) && !EXT_LCD_SUPPLY))
    else $error("halver bits not set independently");

  chk_reset_clear: assert property (
    @(posedge mclk) disable iff (1'b0)
    sys_rst |=> !slow_regulator_halver && !lcd_supply_halver
      && !logic_voltage_select && !fast_regulator_on && !lcd_supply_on
      && !cpu_clock_select && !fast_osc_enable)
    else $error("control bits not cleared by reset");

  chk_halver_always: assert property (
    voltage_halver_on ##1 voltage_halver_on)
    else $error("voltage halver stopped");

  chk_supply_readback: assert property (
    s_rd_supply |=> reg_rdata == $past(supply_reg))
    else $error("supply register read back wrong");

  chk_write_then_read: assert property (
    s_wr_supply ##1 s_rd_supply |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written supply bits not read back");

  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == PMC_RD_NONE)
    else $error("read data not zero without a read");

  chk_lcd_power_off: assert property (
    s_wr_lcd_off |=> !lcd_supply_on && lcd_drive_grounded)
    else $error("lcd supply still on after write of zero");

  chk_osc_write: assert property (
    s_wr_osc |=> cpu_clock_select == $past(reg_wdata[PMC_BIT_CCS])
      && fast_osc_enable == $past(reg_wdata[PMC_BIT_FOE]))
    else $error("oscillator bits do not follow the write");

  chk_osc_hold: assert property (
    !(reg_wr && pmc_hit(reg_addr, PMC_OFF_OSC))
    |=> $stable(cpu_clock_select) && $stable(fast_osc_enable))
    else $error("oscillator bits changed without a write");

  chk_osc_readback: assert property (
    s_wr_osc ##1 s_rd_osc |=> reg_rdata == {2'h0, $past(reg_wdata[1:0], 2)})
    else $error("written oscillator bits not read back");

  chk_halver_status: assert property (
    s_rd_status |=> reg_rdata[PMC_BIT_ST_HALV]
      == !($past(logic_voltage_select) || $past(cpu_clock_select)
      || $past(fast_osc_enable) || $past(fast_regulator_on)))
    else $error("halver status does not match the supply state");

  chk_status_ro: assert property (
    reg_wr && pmc_hit(reg_addr, PMC_OFF_STATUS)
    |=> $stable(supply_reg) && $stable(osc_reg) && $stable(lcdpwr_reg))
    else $error("status write changed a control register");

  chk_vd3_wait_start: assert property (
    $rose(tmr_bus[0].arm) |-> !tmr_bus[0].done)
    else $error("fast supply wait reported at once");

  chk_osc_wait_clear: assert property (
    $fell(tmr_bus[1].arm) |=> !tmr_bus[1].done)
    else $error("oscillator wait not cleared when disabled");

  chk_lcd_wait_start: assert property (
    $rose(tmr_bus[2].arm) |-> !tmr_bus[2].done)
    else $error("lcd supply wait reported at once");

  chk_lcd_read_upper: assert property (
    reg_rd && pmc_hit(reg_addr, PMC_OFF_LCDPWR) |=> reg_rdata[3:1] == 3'h0)
    else $error("lcd power register upper bits not zero");

endmodule
`default_nettype wire

// ===== hw/pmc_settle_timer.sv
// Purpose: counts cycles while armed and flags when the wait has passed
// Assumes: COUNT fits in the counter width
// Notes:   dropping arm restarts the wait from zero
`timescale 1ns/1ps
`default_nettype none
module pmc_settle_timer
  import pmc_pkg::*;
#(
  parameter int unsigned COUNT = 16
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  pmc_timer_if.tmr  tif
);

  localparam logic [PMC_TMR_W-1:0] LAST = PMC_TMR_W'(COUNT);

  logic [PMC_TMR_W-1:0] cnt_reg;
  logic [PMC_TMR_W-1:0] cnt_next;
  wire                  at_end;

  // counter saturates at the wait length
  assign at_end   = (cnt_reg == LAST);
  assign cnt_next = !tif.arm ? '0 : (at_end ? cnt_reg : cnt_reg + 1'b1);
  assign tif.done = at_end;

  // count register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  chk_timer_done_cause: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(tif.done) |-> $past(tif.arm) && $past(cnt_reg) == LAST - 1'b1)
    else $error("settle timer done without full armed count");

endmodule
`default_nettype wire

// ===== hw/pmc_timer_if.sv
// Purpose: arm and done pair between the controller and a settle timer
// Assumes: both ends on mclk
// Notes:   arm is a level; done stays high while arm stays high
`timescale 1ns/1ps
`default_nettype none
interface pmc_timer_if;
  logic arm;
  logic done;
  modport ctrl (output arm, input done);
  modport tmr (input arm, output done);
endinterface
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: self-checking bench for the power mode control block
// Assumes: register port with read data one cycle after the strobe
// Notes:   settle waits shortened; a second copy has the external lcd option
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmc_pkg::*;
  localparam int VD3_W = 20;
  localparam int OSC_W = 30;
  localparam int LCD_W = 40;
  localparam int LIMIT = 5000;

  logic                  mclk;
  logic                  sys_rst;
  logic [PMC_ADDR_W-1:0] reg_addr;
  logic [PMC_DATA_W-1:0] reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [PMC_DATA_W-1:0] reg_rdata;
  logic                  lvs, fro, srh, lsh, lso, gnd, ccs, foe;
  logic [3:0]            contrast;
  logic                  slow_on, halv_on, lso_x, lsh_x;
  logic [3:0]            rd_val;
  int                    num_errors;
  int                    total_checks;
  int                    cycles;

  pmc_power_ctrl #(.VD3_WAIT_CYCLES(VD3_W), .OSC_WAIT_CYCLES(OSC_W),
    .LCD_WAIT_CYCLES(LCD_W), .EXT_LCD_SUPPLY(1'b0)) pmc_power_ctrl_inst (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .logic_voltage_select(lvs),
    .fast_regulator_on(fro), .slow_regulator_halver(srh),
    .lcd_supply_halver(lsh), .lcd_supply_on(lso), .lcd_drive_grounded(gnd),
    .cpu_clock_select(ccs), .fast_osc_enable(foe),
    .lcd_contrast_level(contrast), .slow_regulator_on(slow_on),
    .voltage_halver_on(halv_on));

  // copy built with the external lcd supply option
  pmc_power_ctrl #(.VD3_WAIT_CYCLES(VD3_W), .OSC_WAIT_CYCLES(OSC_W),
    .LCD_WAIT_CYCLES(LCD_W), .EXT_LCD_SUPPLY(1'b1)) pmc_power_ctrl_ext_inst (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(), .logic_voltage_select(), .fast_regulator_on(),
    .slow_regulator_halver(), .lcd_supply_halver(lsh_x),
    .lcd_supply_on(lso_x), .lcd_drive_grounded(), .cpu_clock_select(),
    .fast_osc_enable(), .lcd_contrast_level(), .slow_regulator_on(),
    .voltage_halver_on());

  // clock and hang guard
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare a four-bit word
  task automatic chk_data(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  // compare a single control output
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // one-cycle write, outputs settled on return
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // one-cycle read, data taken in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [3:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [15:0] a, input logic [3:0] d,
                       output logic [3:0] q);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    #1;
    q = reg_rdata;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  // all state and outputs except contrast at their reset values
  task automatic chk_reset_state();
    rd(PMC_OFF_SUPPLY, rd_val); chk_data(rd_val, 4'h0);
    rd(PMC_OFF_LCDPWR, rd_val); chk_data(rd_val, 4'h0);
    rd(PMC_OFF_OSC, rd_val); chk_data(rd_val, 4'h0);
    chk_bit(srh, 1'b0);
    chk_bit(lsh, 1'b0);
    chk_bit(lvs | fro | lso | ccs | foe, 1'b0);
    chk_bit(gnd, 1'b1);
    chk_bit(slow_on, 1'b1);
    chk_bit(halv_on, 1'b1);
  endtask

  initial begin
    sys_rst = 1'b1; reg_addr = 16'h0000; reg_wdata = 4'h0;
    reg_wr = 1'b0; reg_rd = 1'b0;
    num_errors = 0; total_checks = 0; cycles = 0;
    do_reset();
    chk_reset_state();
    $display("test reset values done");
    // each supply bit alone, outputs and read back
    for (int i = 0; i < 4; i++) begin
      wr_rd(PMC_OFF_SUPPLY, 4'h1 << i, rd_val);
      chk_data({lsh, srh, fro, lvs}, 4'h1 << i);
      chk_data(rd_val, 4'h1 << i);
    end
    wr(PMC_OFF_SUPPLY, 4'hC);
    chk_data({lsh, srh, fro, lvs}, 4'hC);
    chk_bit(lsh_x, 1'b0);
    $display("test supply bits done");
    // lcd supply on and off, upper bits read as zero
    wr(PMC_OFF_LCDPWR, 4'hF);
    chk_bit(lso, 1'b1);
    chk_bit(gnd, 1'b0);
    chk_bit(lso_x, 1'b0);
    rd(PMC_OFF_LCDPWR, rd_val); chk_data(rd_val, 4'h1);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[2], 1'b0);
    repeat (LCD_W + 4) @(posedge mclk);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[2], 1'b1);
    wr(PMC_OFF_LCDPWR, 4'h0);
    chk_bit(gnd, 1'b1);
    $display("test lcd supply done");
    // all sixteen contrast settings
    for (int i = 0; i < 16; i++) begin
      wr(PMC_OFF_CONTRAST, 4'(i));
      chk_data(contrast, 4'(i));
      rd(PMC_OFF_CONTRAST, rd_val); chk_data(rd_val, 4'(i));
    end
    $display("test contrast done");
    // enter fast operation in order with the waits
    wr(PMC_OFF_SUPPLY, 4'h0);
    wr(PMC_OFF_SUPPLY, 4'h2);
    chk_bit(fro, 1'b1);
    wr(PMC_OFF_SUPPLY, 4'h3);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[0], 1'b0);
    chk_bit(rd_val[3], 1'b0);
    repeat (VD3_W + 4) @(posedge mclk);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[0], 1'b1);
    wr_rd(PMC_OFF_OSC, 4'h2, rd_val);
    chk_bit(foe, 1'b1);
    chk_data(rd_val, 4'h2);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[1], 1'b0);
    repeat (OSC_W + 4) @(posedge mclk);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[1], 1'b1);
    wr(PMC_OFF_OSC, 4'h3);
    chk_bit(ccs, 1'b1);
    $display("test fast entry done");
    // leave fast operation and set slow halver
    wr(PMC_OFF_OSC, 4'h2);
    wr(PMC_OFF_OSC, 4'h0);
    wr(PMC_OFF_SUPPLY, 4'h2);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[3], 1'b0);
    wr(PMC_OFF_SUPPLY, 4'h0);
    chk_bit(fro, 1'b0);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[3], 1'b1);
    wr(PMC_OFF_SUPPLY, 4'h4);
    chk_bit(srh, 1'b1);
    $display("test fast exit done");
    // unmapped and read-only places
    wr(16'hFF7F, 4'hF);
    rd(16'hFF7F, rd_val); chk_data(rd_val, 4'h0);
    wr(PMC_OFF_STATUS, 4'h0);
    rd(PMC_OFF_SUPPLY, rd_val); chk_data(rd_val, 4'h4);
    rd(PMC_OFF_STATUS, rd_val); chk_bit(rd_val[3], 1'b1);
    $display("test unmapped access done");
    // second reset with state set
    wr(PMC_OFF_SUPPLY, 4'hB);
    wr(PMC_OFF_LCDPWR, 4'h1);
    wr(PMC_OFF_OSC, 4'h3);
    do_reset();
    chk_reset_state();
    $display("test second reset done");
    // halver modes entered straight from slow operation
    wr(PMC_OFF_CONTRAST, 4'h6);
    wr(PMC_OFF_SUPPLY, 4'h4);
    chk_bit(srh, 1'b1);
    wr(PMC_OFF_SUPPLY, 4'hC);
    chk_bit(lsh, 1'b1);
    chk_data(contrast, 4'h6);
    $display("test slow halver entry done");
    finish_test();
  end
endmodule
`default_nettype wire
